// >>> hdl/fsic_consts.vh
`ifndef FSIC_CONSTS_VH
`define FSIC_CONSTS_VH

// register indices on the internal control port
`define FSIC_ADDR_W 2
`define FSIC_ADDR_REACT_CORE_IO 2'h0
`define FSIC_ADDR_REACT_MON1 2'h1
`define FSIC_ADDR_FSM_CFG 2'h2
`define FSIC_ADDR_SCALING 2'h3

// reset values of the stored fields
`define FSIC_RST_REACT_OV 2'h3
`define FSIC_RST_REACT_UV 2'h1
`define FSIC_RST_CEILING 2'h1
`define FSIC_RST_PULSE_SEL 1'h0
`define FSIC_RST_TIMER_OFF 1'h0
`define FSIC_RST_TRIM 5'h00

// field positions, 16-bit data word
`define FSIC_CORE_OV_HI 15
`define FSIC_CORE_OV_LO 14
`define FSIC_CORE_UV_HI 13
`define FSIC_CORE_UV_LO 12
`define FSIC_LOW_OV_HI 3
`define FSIC_LOW_OV_LO 2
`define FSIC_LOW_UV_HI 1
`define FSIC_LOW_UV_LO 0
`define FSIC_CEIL_HI 15
`define FSIC_CEIL_LO 14
`define FSIC_PULSE_SEL_BIT 9
`define FSIC_TIMER_OFF_BIT 4
`define FSIC_FCNT_HI 3
`define FSIC_FCNT_LO 0
`define FSIC_TRIM_HI 15
`define FSIC_TRIM_LO 11

// timing
`define FSIC_CLK_KHZ 250000
`define FSIC_PULSE_LONG_MS 10
`define FSIC_PULSE_SHORT_US 1000
`define FSIC_LONG_LOW_MS 8000

// scaling trim
`define FSIC_TRIM_STEP_UV 6250
`define FSIC_TRIM_MAX_CODE 5'h10

`endif

// >>> hdl/fsic_mon_react.v
`timescale 1ns/100ps
`include "fsic_consts.vh"

module fsic_mon_react #(
  parameter N_MON = 6
) (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire [N_MON-1:0] i_mon_fire,
  input wire [2*N_MON-1:0] i_reaction_cfg,
  output reg [N_MON-1:0] o_mon_event,
  output reg [2*N_MON-1:0] o_mon_reaction
);

  genvar g;
  generate
    for (g = 0; g < N_MON; g = g + 1) begin : g_mon
      reg s1;
      reg s2;
      reg s3;
      reg state;
      always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          state <= 1'b0;
          o_mon_event[g] <= 1'b0;
          o_mon_reaction[2*g+1:2*g] <= 2'h0;
        end else begin
          s1 <= i_mon_fire[g];
          s2 <= s1;
          s3 <= s2;
          o_mon_event[g] <= 1'b0;
          // change counts only once the two later stages agree
          if (s2 == s3 && s2 != state) begin
            state <= s2;
            if (s2) begin
              o_mon_event[g] <= 1'b1;
              o_mon_reaction[2*g+1:2*g] <= i_reaction_cfg[2*g+1:2*g];
            end
          end
        end
      end
    end
  endgenerate

endmodule

// >>> hdl/fsic_regs.v
`timescale 1ns/100ps
`include "fsic_consts.vh"

module fsic_regs #(
  parameter PULSE_LONG_CYC = `FSIC_PULSE_LONG_MS * `FSIC_CLK_KHZ,
  parameter PULSE_SHORT_CYC = (`FSIC_PULSE_SHORT_US * `FSIC_CLK_KHZ) / 1000,
  parameter LONG_LOW_CYC = `FSIC_LONG_LOW_MS * `FSIC_CLK_KHZ
) (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire [`FSIC_ADDR_W-1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  input wire [3:0] i_fault_count_value,
  output wire [1:0] o_fault_count_ceiling,
  output wire [4:0] o_static_scaling_trim,
  output reg [16:0] o_trim_offset_uv,
  input wire i_reset_request,
  output wire o_reset_out_pin_o,
  output wire o_reset_out_pin_oe,
  input wire i_reset_out_pin_i,
  output reg o_long_low_expired,
  input wire i_core_mon_over,
  input wire i_core_mon_under,
  input wire i_io_rail_over,
  input wire i_io_rail_under,
  input wire i_aux_mon_over,
  input wire i_aux_mon_under,
  output wire [5:0] o_mon_event,
  output wire [11:0] o_mon_reaction
);

  reg [1:0] core_mon_over_reaction;
  reg [1:0] core_mon_under_reaction;
  reg [1:0] io_rail_over_reaction;
  reg [1:0] io_rail_under_reaction;
  reg [1:0] aux_mon_over_reaction;
  reg [1:0] aux_mon_under_reaction;
  reg [1:0] fault_count_ceiling;
  reg reset_pulse_length_sel;
  reg long_low_timer_off;
  reg [4:0] static_scaling_trim;
  reg [15:0] next_rdata;
  reg [31:0] pulse_cnt;
  reg pulse_active;
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg pin_low;
  reg [31:0] low_cnt;
  wire [4:0] trim_clamped;

  // register writes; POR is the only reset of these fields
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      core_mon_over_reaction <= `FSIC_RST_REACT_OV;
      core_mon_under_reaction <= `FSIC_RST_REACT_UV;
      io_rail_over_reaction <= `FSIC_RST_REACT_OV;
      io_rail_under_reaction <= `FSIC_RST_REACT_UV;
      aux_mon_over_reaction <= `FSIC_RST_REACT_OV;
      aux_mon_under_reaction <= `FSIC_RST_REACT_UV;
      fault_count_ceiling <= `FSIC_RST_CEILING;
      reset_pulse_length_sel <= `FSIC_RST_PULSE_SEL;
      long_low_timer_off <= `FSIC_RST_TIMER_OFF;
      static_scaling_trim <= `FSIC_RST_TRIM;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `FSIC_ADDR_REACT_CORE_IO: begin
          core_mon_over_reaction <= i_reg_wdata[`FSIC_CORE_OV_HI:`FSIC_CORE_OV_LO];
          core_mon_under_reaction <= i_reg_wdata[`FSIC_CORE_UV_HI:`FSIC_CORE_UV_LO];
          io_rail_over_reaction <= i_reg_wdata[`FSIC_LOW_OV_HI:`FSIC_LOW_OV_LO];
          io_rail_under_reaction <= i_reg_wdata[`FSIC_LOW_UV_HI:`FSIC_LOW_UV_LO];
        end
        `FSIC_ADDR_REACT_MON1: begin
          aux_mon_over_reaction <= i_reg_wdata[`FSIC_LOW_OV_HI:`FSIC_LOW_OV_LO];
          aux_mon_under_reaction <= i_reg_wdata[`FSIC_LOW_UV_HI:`FSIC_LOW_UV_LO];
        end
        `FSIC_ADDR_FSM_CFG: begin
          // fault count bits are not stored, so writes there vanish
          fault_count_ceiling <= i_reg_wdata[`FSIC_CEIL_HI:`FSIC_CEIL_LO];
          reset_pulse_length_sel <= i_reg_wdata[`FSIC_PULSE_SEL_BIT];
          long_low_timer_off <= i_reg_wdata[`FSIC_TIMER_OFF_BIT];
        end
        `FSIC_ADDR_SCALING: begin
          static_scaling_trim <= i_reg_wdata[`FSIC_TRIM_HI:`FSIC_TRIM_LO];
        end
        default: begin
          static_scaling_trim <= static_scaling_trim;
        end
      endcase
    end
  end

  // read mux; reserved bits read zero
  always @* begin
    next_rdata = 16'h0000;
    case (i_reg_addr)
      `FSIC_ADDR_REACT_CORE_IO: begin
        next_rdata[`FSIC_CORE_OV_HI:`FSIC_CORE_OV_LO] = core_mon_over_reaction;
        next_rdata[`FSIC_CORE_UV_HI:`FSIC_CORE_UV_LO] = core_mon_under_reaction;
        next_rdata[`FSIC_LOW_OV_HI:`FSIC_LOW_OV_LO] = io_rail_over_reaction;
        next_rdata[`FSIC_LOW_UV_HI:`FSIC_LOW_UV_LO] = io_rail_under_reaction;
      end
      `FSIC_ADDR_REACT_MON1: begin
        next_rdata[`FSIC_LOW_OV_HI:`FSIC_LOW_OV_LO] = aux_mon_over_reaction;
        next_rdata[`FSIC_LOW_UV_HI:`FSIC_LOW_UV_LO] = aux_mon_under_reaction;
      end
      `FSIC_ADDR_FSM_CFG: begin
        next_rdata[`FSIC_CEIL_HI:`FSIC_CEIL_LO] = fault_count_ceiling;
        next_rdata[`FSIC_PULSE_SEL_BIT] = reset_pulse_length_sel;
        next_rdata[`FSIC_TIMER_OFF_BIT] = long_low_timer_off;
        next_rdata[`FSIC_FCNT_HI:`FSIC_FCNT_LO] = i_fault_count_value;
      end
      `FSIC_ADDR_SCALING: begin
        next_rdata[`FSIC_TRIM_HI:`FSIC_TRIM_LO] = static_scaling_trim;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // reset pulse; length latched at the start so a mid-pulse write cannot cut it
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pulse_active <= 1'b0;
      pulse_cnt <= 32'h0000_0000;
    end else if (i_reset_request && !pulse_active) begin
      pulse_active <= 1'b1;
      if (reset_pulse_length_sel) begin
        pulse_cnt <= PULSE_SHORT_CYC - 1;
      end else begin
        pulse_cnt <= PULSE_LONG_CYC - 1;
      end
    end else if (pulse_active) begin
      if (pulse_cnt == 32'h0000_0000) begin
        pulse_active <= 1'b0;
      end else begin
        pulse_cnt <= pulse_cnt - 32'h0000_0001;
      end
    end
  end

  // open drain: drive low only
  assign o_reset_out_pin_o = 1'b0;
  assign o_reset_out_pin_oe = pulse_active;

  // pin sense synchroniser; external pullers also count as low
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_low <= 1'b0;
    end else begin
      pin_s1 <= i_reset_out_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_low <= ~pin_s2;
      end
    end
  end

  // 8 s low counter, held cleared while disabled
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt <= 32'h0000_0000;
      o_long_low_expired <= 1'b0;
    end else if (long_low_timer_off || !pin_low) begin
      low_cnt <= 32'h0000_0000;
      o_long_low_expired <= 1'b0;
    end else if (low_cnt >= LONG_LOW_CYC - 1) begin
      o_long_low_expired <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end

  // trim offset magnitude in microvolts, codes past the top clamp to -100 mV
  assign trim_clamped = (static_scaling_trim > `FSIC_TRIM_MAX_CODE) ?
                        `FSIC_TRIM_MAX_CODE : static_scaling_trim;

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_trim_offset_uv <= 17'h0_0000;
    end else begin
      o_trim_offset_uv <= trim_clamped * 17'd6250;
    end
  end

  assign o_fault_count_ceiling = fault_count_ceiling;
  assign o_static_scaling_trim = static_scaling_trim;

  fsic_mon_react #(
    .N_MON(6)
  ) u_react (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_mon_fire({i_aux_mon_under, i_aux_mon_over, i_io_rail_under,
                 i_io_rail_over, i_core_mon_under, i_core_mon_over}),
    .i_reaction_cfg({aux_mon_under_reaction, aux_mon_over_reaction,
                     io_rail_under_reaction, io_rail_over_reaction,
                     core_mon_under_reaction, core_mon_over_reaction}),
    .o_mon_event(o_mon_event),
    .o_mon_reaction(o_mon_reaction)
  );

endmodule

// >>> bench/fsic_regs_checker.sv
`timescale 1ns/100ps
module fsic_regs_checker #(
  parameter PULSE_LONG_CYC = 20,
  parameter PULSE_SHORT_CYC = 5,
  parameter LONG_LOW_CYC = 30
) (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire [1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_rvalid,
  input wire [3:0] i_fault_count_value,
  input wire [4:0] o_static_scaling_trim,
  input wire [16:0] o_trim_offset_uv,
  input wire i_reset_request,
  input wire o_reset_out_pin_o,
  input wire o_reset_out_pin_oe,
  input wire i_reset_out_pin_i,
  input wire o_long_low_expired,
  input wire [5:0] o_mon_event,
  input wire [11:0] o_mon_reaction
);
  reg [31:0] oe_len;
  reg [31:0] low_len;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // counters, since pulse figures exceed any repetition count
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_len <= 32'h0;
      low_len <= 32'h0;
    end else begin
      oe_len <= o_reset_out_pin_oe ? oe_len + 32'h1 : 32'h0;
      low_len <= i_reset_out_pin_i ? 32'h0 : low_len + 32'h1;
    end
  end
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_count_live: assert property ((i_reg_rd && i_reg_addr == 2'h2) |=>
    o_reg_rdata[3:0] == $past(i_fault_count_value)) else $error("fault count not live");
  a_trim_write: assert property ((i_reg_wr && i_reg_addr == 2'h3) |=>
    o_static_scaling_trim == $past(i_reg_wdata[15:11])) else $error("trim not stored");
  a_trim_scale: assert property (o_trim_offset_uv == (($past(o_static_scaling_trim) > 5'h10) ?
    17'd100000 : $past(o_static_scaling_trim) * 17'd6250)) else $error("bad trim offset");
  a_pulse_cause: assert property ($rose(o_reset_out_pin_oe) |-> $past(i_reset_request))
    else $error("pulse without request");
  a_pulse_length: assert property ($fell(o_reset_out_pin_oe) |->
    (oe_len == PULSE_SHORT_CYC || oe_len == PULSE_LONG_CYC)) else $error("bad pulse length");
  a_open_drain: assert property (o_reset_out_pin_o == 1'b0)
    else $error("pin driven high");
  a_expire_low: assert property ($rose(o_long_low_expired) |-> low_len >= LONG_LOW_CYC)
    else $error("early long low");
  a_event_single: assert property (o_mon_event[0] |=> !o_mon_event[0])
    else $error("event too long");
  a_code_held: assert property ($changed(o_mon_reaction[1:0]) |-> o_mon_event[0])
    else $error("code changed without event");
endmodule

// >>> bench/fsic_pin_model.sv
`timescale 1ns/100ps
module fsic_pin_model (
  input wire i_oe,
  input wire i_drv,
  input wire i_ext_low,
  output wire o_pin
);
  // pulled-up reset net; any party pulling low wins
  assign o_pin = !((i_oe && !i_drv) || i_ext_low);
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg i_clk_sys = 1'b0;
  reg i_rstn = 1'b0;
  reg [1:0] addr = 2'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [15:0] wdata = 16'h0;
  reg [3:0] fc = 4'h0;
  reg req = 1'b0;
  reg ext_low = 1'b0;
  reg [5:0] mon = 6'h0;
  reg [4:0] code;
  wire [15:0] rdata;
  wire rvalid, pin_o, pin_oe, pin, expd;
  wire [1:0] ceil;
  wire [4:0] trim;
  wire [16:0] uv;
  wire [5:0] ev;
  wire [11:0] react;
  integer err_total = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer n, k;
  always #2 i_clk_sys = ~i_clk_sys;
  fsic_regs #(.PULSE_LONG_CYC(20), .PULSE_SHORT_CYC(5), .LONG_LOW_CYC(30)) dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_fault_count_value(fc), .o_fault_count_ceiling(ceil), .o_static_scaling_trim(trim),
    .o_trim_offset_uv(uv), .i_reset_request(req), .o_reset_out_pin_o(pin_o),
    .o_reset_out_pin_oe(pin_oe), .i_reset_out_pin_i(pin), .o_long_low_expired(expd),
    .i_core_mon_over(mon[0]), .i_core_mon_under(mon[1]), .i_io_rail_over(mon[2]),
    .i_io_rail_under(mon[3]), .i_aux_mon_over(mon[4]), .i_aux_mon_under(mon[5]),
    .o_mon_event(ev), .o_mon_reaction(react));
  fsic_pin_model pm (.i_oe(pin_oe), .i_drv(pin_o), .i_ext_low(ext_low), .o_pin(pin));
  task chk(input [16:0] seen, input [16:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task conclude;
    begin
      $display("mismatches %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  task wr_reg(input [1:0] a, input [15:0] d);
    begin
      @(posedge i_clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk_sys);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [1:0] a, input [15:0] want);
    begin
      @(posedge i_clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk_sys);
      rd <= 1'b0;
      #1;
      chk(rvalid, 17'h1);
      chk(rdata, want);
    end
  endtask
  task t_reset_vals;
    begin
      rd_reg(2'h0, 16'hd00d);
      rd_reg(2'h1, 16'h000d);
      rd_reg(2'h2, 16'h4000);
      rd_reg(2'h3, 16'h0000);
      chk(ceil, 17'h1);
    end
  endtask
  task t_fault_count;
    begin
      wr_reg(2'h2, 16'h400f);
      fc <= 4'hc;
      rd_reg(2'h2, 16'h400c);
      @(posedge i_clk_sys);
      fc <= 4'h5;
      rd_reg(2'h2, 16'h4005);
      @(posedge i_clk_sys);
      fc <= 4'h0;
    end
  endtask
  task t_pulse;
    for (k = 0; k < 2; k = k + 1) begin
      wr_reg(2'h2, k ? 16'h4000 : 16'h4200);
      @(posedge i_clk_sys);
      req <= 1'b1;
      @(posedge i_clk_sys);
      req <= 1'b0;
      #1;
      n = 0;
      repeat (40) begin
        if (pin === 1'b0) n = n + 1;
        @(posedge i_clk_sys);
        #1;
      end
      chk(n, k ? 17'd20 : 17'd5);
    end
  endtask
  task t_long_low;
    begin
      @(posedge i_clk_sys);
      ext_low <= 1'b1;
      n = 0;
      while (expd !== 1'b1 && n < 50) begin
        @(posedge i_clk_sys);
        #1;
        n = n + 1;
      end
      chk(n >= 30 && n <= 40, 17'h1);
      @(posedge i_clk_sys);
      ext_low <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      #1;
      chk(expd, 17'h0);
      wr_reg(2'h2, 16'h4010);
      ext_low <= 1'b1;
      repeat (60) @(posedge i_clk_sys);
      #1;
      chk(expd, 17'h0);
      @(posedge i_clk_sys);
      ext_low <= 1'b0;
      rd_reg(2'h2, 16'h4010);
    end
  endtask
  task t_trim;
    for (k = 0; k < 3; k = k + 1) begin
      code = (k == 0) ? 5'h01 : (k == 1) ? 5'h10 : 5'h11;
      wr_reg(2'h3, {code, 11'h000});
      @(posedge i_clk_sys);
      #1;
      chk(trim, code);
      chk(uv, ((code > 5'h10) ? 17'd16 : code) * 17'd6250);
    end
  endtask
  task t_monitors;
    begin
      wr_reg(2'h0, 16'h6009);
      wr_reg(2'h1, 16'h0006);
      for (k = 0; k < 6; k = k + 1) begin
        @(posedge i_clk_sys);
        mon[k] <= 1'b1;
        n = 0;
        while (ev[k] !== 1'b1 && n < 10) begin
          @(posedge i_clk_sys);
          #1;
          n = n + 1;
        end
        chk(ev[k], 17'h1);
        chk(react[2*k +: 2], 12'h969 >> (2 * k) & 12'h003);
        @(posedge i_clk_sys);
        mon[k] <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
      end
      chk(react, 17'h969);
    end
  endtask
  task t_second_por;
    begin
      wr_reg(2'h2, 16'hc210);
      #1;
      chk(ceil, 17'h3);
      @(posedge i_clk_sys);
      i_rstn <= 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      rd_reg(2'h2, 16'h4000);
      rd_reg(2'h3, 16'h0000);
      rd_reg(2'h0, 16'hd00d);
      chk(ceil, 17'h1);
    end
  endtask
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_reset_vals;
    t_fault_count;
    t_pulse;
    t_long_low;
    t_trim;
    t_monitors;
    t_second_por;
    conclude;
  end
endmodule
bind fsic_regs fsic_regs_checker #(.PULSE_LONG_CYC(PULSE_LONG_CYC),
  .PULSE_SHORT_CYC(PULSE_SHORT_CYC), .LONG_LOW_CYC(LONG_LOW_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_fault_count_value(i_fault_count_value),
  .o_static_scaling_trim(o_static_scaling_trim), .o_trim_offset_uv(o_trim_offset_uv),
  .i_reset_request(i_reset_request), .o_reset_out_pin_o(o_reset_out_pin_o),
  .o_reset_out_pin_oe(o_reset_out_pin_oe), .i_reset_out_pin_i(i_reset_out_pin_i),
  .o_long_low_expired(o_long_low_expired), .o_mon_event(o_mon_event),
  .o_mon_reaction(o_mon_reaction));
